// ==== sfpe_ctrl.sv ====
// Summary of operation
// - Quad program: 32h, address, data on lanes
// - Quad program needs quad lane enable set
// - Program at most 256 bytes per page
// - Program and erases need write latch set
// - 20h erases addressed 4 KB sector
// - 52h erases addressed 32 KB block
// - D8h erases addressed 64 KB block
// - C7h or 60h erases whole array
// - Select rise off byte boundary discards command
// - Valid command starts timed cycle, busy high
// - Status read serviced while erase runs
// - Cycle completion clears write latch flag
// - Protected sector or block erase skipped
// - Chip erase refused if anything protected
// - Suspend only during sector/block erase
// - Suspended: other regions may be programmed
// - Suspended: no status write, no erase
// - Suspend halts erase, then busy clears
// - Resume sets busy, finishes erase
// - Resume ignored unless suspended
// - Page overflow wraps within same page
//
// Purpose: Serial command decode and self-timed program/erase sequencing.
// Assumes: Serial pins are asynchronous and oversampled by clk_sys.
// Notes:   Opcode is serial on lane 0; quad program address and data
//          are four bits per edge. Array access is a write/erase port.
`timescale 1ns/100ps
module sfpe_ctrl #(
  parameter int ADDR_W = 21,
  parameter int PROG_TIME_US = 1000,
  parameter int SECT_TIME_US = 100000,
  parameter int HALF_BLOCK_ERASE_TIME_US = 500000,
  parameter int FULL_BLOCK_ERASE_TIME_US = 1000000,
  parameter int WHOLE_ARRAY_ERASE_TIME_US = 5000000,
  parameter int SUSP_TIME_US = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_cs_n,
  input wire logic spi_clk,
  input wire logic data_lane0_i,
  output logic data_lane0_o,
  output logic data_lane0_oe,
  input wire logic data_lane1_i,
  output logic data_lane1_o,
  output logic data_lane1_oe,
  input wire logic data_lane2_i,
  output logic data_lane2_o,
  output logic data_lane2_oe,
  input wire logic data_lane3_i,
  output logic data_lane3_o,
  output logic data_lane3_oe,
  output logic arr_wr_en,
  output logic [23:0] arr_wr_addr,
  output logic [7:0] arr_wr_data,
  output logic arr_erase_en,
  output logic [23:0] arr_erase_base,
  output logic [4:0] arr_erase_log2
);
  localparam logic [31:0] PROG_CYC = 32'(PROG_TIME_US * sfpe_pkg::CLK_MHZ);
  localparam logic [31:0] SECT_CYC = 32'(SECT_TIME_US * sfpe_pkg::CLK_MHZ);
  localparam logic [31:0] HALF_CYC =
    32'(HALF_BLOCK_ERASE_TIME_US * sfpe_pkg::CLK_MHZ);
  localparam logic [31:0] FULL_CYC =
    32'(FULL_BLOCK_ERASE_TIME_US * sfpe_pkg::CLK_MHZ);
  localparam logic [31:0] CHIP_CYC =
    32'(WHOLE_ARRAY_ERASE_TIME_US * sfpe_pkg::CLK_MHZ);
  localparam logic [31:0] SUSP_CYC = 32'(SUSP_TIME_US * sfpe_pkg::CLK_MHZ);
  localparam logic [24:0] MEM_BYTES = 25'(1) << ADDR_W;

  typedef enum logic [2:0] {
    SFPE_IDLE, SFPE_PROG, SFPE_ERASE, SFPE_CHIP, SFPE_HALT
  } sfpe_state_t;

  // True when region [base, base+2^lg) touches the protected range
  function automatic logic sfpe_prot_hit(input logic [23:0] base,
      input logic [4:0] lg, input logic tb, input logic [2:0] bp,
      input logic sec);
    logic [24:0] psz;
    logic [24:0] lo;
    logic [24:0] hi;
    logic [4:0] sh;
    psz = '0;
    lo = {1'b0, base};
    hi = lo + (25'(1) << lg) - 25'(1);
    sh = '0;
    if (bp == sfpe_pkg::BP_ALL || (!sec && bp >= sfpe_pkg::BP_CAP)) begin
      psz = MEM_BYTES;
    end else if (bp != 3'h0) begin
      if (sec) begin
        sh = sfpe_pkg::LOG_SECT + 5'(bp) - 5'h01;
        if (sh > sfpe_pkg::LOG_SEC_MAX) begin
          sh = sfpe_pkg::LOG_SEC_MAX;
        end
      end else begin
        sh = sfpe_pkg::LOG_BLK64 + 5'(bp) - 5'h01;
      end
      psz = 25'(1) << sh;
      if (psz > MEM_BYTES) begin
        psz = MEM_BYTES;
      end
    end
    if (psz == '0) begin
      sfpe_prot_hit = 1'b0;
    end else if (tb) begin
      sfpe_prot_hit = lo < psz;
    end else begin
      sfpe_prot_hit = hi >= (MEM_BYTES - psz);
    end
  endfunction

  // Pin synchronisers: stage 1 is read only by stage 2
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  always_ff @(posedge clk_sys) begin
    pin_s1_q <= {spi_cs_n, spi_clk, data_lane3_i, data_lane2_i,
                 data_lane1_i, data_lane0_i};
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q[5:4];
  end
  wire cs_act = ~pin_s2_q[5];
  wire cs_fall = ~pin_s2_q[5] & pin_s3_q[1];
  wire cs_rise = pin_s2_q[5] & ~pin_s3_q[1];
  wire sck_rise = cs_act & pin_s2_q[4] & ~pin_s3_q[0];
  wire sck_fall = cs_act & ~pin_s2_q[4] & pin_s3_q[0];
  wire [3:0] nib = pin_s2_q[3:0];

  // Control and engine state
  logic [5:0] ctrl_q;
  logic wel_q;
  logic susp_q;
  sfpe_state_t st_q;
  logic [31:0] cnt_q;
  logic [31:0] left_q;
  logic [23:0] ebase_q;
  logic [4:0] elog_q;
  logic [23:0] pbase_q;
  logic [8:0] drain_q;

  wire qe = ctrl_q[sfpe_pkg::CTRL_QE];
  wire tb = ctrl_q[sfpe_pkg::CTRL_TB];
  wire [2:0] bp = ctrl_q[sfpe_pkg::CTRL_BP_LO +: 3];
  wire sec = ctrl_q[sfpe_pkg::CTRL_SEC];
  wire busy = st_q != SFPE_IDLE;
  wire [7:0] sr_byte = {1'b0, sec, tb, bp, wel_q, busy};

  // Frame receiver
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic [11:0] nrise_q;
  logic nib_ph_q;
  logic [3:0] hi_nib_q;
  logic [7:0] bptr_q;
  logic [7:0] sr_sh_q;
  logic [255:0] bvld_q;
  logic [7:0] pbuf [256];

  wire in_op = nrise_q < sfpe_pkg::RISE_OP;
  wire is_qpp = op_q == sfpe_pkg::OP_QPP;
  wire is_rdsr = op_q == sfpe_pkg::OP_RDSR;
  wire q_addr = nrise_q < sfpe_pkg::RISE_QADDR_END;
  wire cap_ok = st_q != SFPE_PROG; // buffer busy while draining
  wire data_wr = sck_rise & !in_op & is_qpp & !q_addr & nib_ph_q & cap_ok;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_q <= '0;
      addr_q <= '0;
      nrise_q <= '0;
      nib_ph_q <= 1'b0;
      hi_nib_q <= '0;
      bptr_q <= '0;
      sr_sh_q <= '0;
    end else if (cs_fall) begin
      nrise_q <= '0;
      nib_ph_q <= 1'b0;
    end else if (sck_rise) begin
      if (nrise_q != sfpe_pkg::RISE_MAX) begin
        nrise_q <= nrise_q + 12'h001;
      end
      if (in_op) begin
        op_q <= {op_q[6:0], nib[0]};
        if (nrise_q == sfpe_pkg::RISE_OP - 12'h001) begin
          sr_sh_q <= sr_byte;
        end
      end else if (is_qpp) begin
        if (q_addr) begin
          addr_q <= {addr_q[19:0], nib};
          if (nrise_q == sfpe_pkg::RISE_QADDR_END - 12'h001) begin
            bptr_q <= {addr_q[3:0], nib};
          end
        end else begin
          nib_ph_q <= ~nib_ph_q;
          hi_nib_q <= nib;
          if (data_wr) begin
            bptr_q <= bptr_q + 8'h01;
          end
        end
      end else begin
        addr_q <= {addr_q[22:0], nib[0]};
      end
    end else if (sck_fall && !in_op && is_rdsr) begin
      sr_sh_q <= {sr_sh_q[6:0], sr_sh_q[7]};
    end
  end

  // Page buffer: bytes past the page end land over earlier ones
  always_ff @(posedge clk_sys) begin
    if (data_wr) begin
      pbuf[bptr_q] <= {hi_nib_q, nib};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bvld_q <= '0;
    end else if (cs_fall && cap_ok) begin
      bvld_q <= '0;
    end else if (data_wr) begin
      bvld_q[bptr_q] <= 1'b1;
    end
  end

  // Status output on lane 1, changed after falling serial edges
  logic lane1_q;
  always_ff @(posedge clk_sys) begin
    if (rst || cs_rise) begin
      lane1_q <= 1'b0;
    end else if (sck_fall && !in_op && is_rdsr) begin
      lane1_q <= sr_sh_q[7];
    end
  end
  assign data_lane1_o = lane1_q;
  assign data_lane1_oe = cs_act & !in_op & is_rdsr;
  assign data_lane0_o = 1'b0;
  assign data_lane0_oe = 1'b0;
  assign data_lane2_o = 1'b0;
  assign data_lane2_oe = 1'b0;
  assign data_lane3_o = 1'b0;
  assign data_lane3_oe = 1'b0;

  // Commit decode at select release; only whole frames count
  wire is_se = op_q == sfpe_pkg::OP_SE;
  wire is_b32 = op_q == sfpe_pkg::OP_BE32;
  wire is_b64 = op_q == sfpe_pkg::OP_BE64;
  wire is_ce = op_q == sfpe_pkg::OP_CE1 || op_q == sfpe_pkg::OP_CE2;
  wire len_op = nrise_q == sfpe_pkg::RISE_OP;
  wire len_addr = nrise_q == sfpe_pkg::RISE_ADDR;
  wire len_q = nrise_q >= sfpe_pkg::RISE_QMIN && !nib_ph_q;
  wire idle = st_q == SFPE_IDLE;
  wire [4:0] rlog = is_se ? sfpe_pkg::LOG_SECT :
                    is_b32 ? sfpe_pkg::LOG_BLK32 : sfpe_pkg::LOG_BLK64;
  wire [23:0] rmask = ~((24'h000001 << rlog) - 24'h000001);
  wire [23:0] rbase = addr_q & rmask;
  wire [23:0] pmask = ~((24'h000001 << sfpe_pkg::LOG_PAGE) - 24'h000001);
  wire [23:0] pbase = addr_q & pmask;
  wire [23:0] emask = ~((24'h000001 << elog_q) - 24'h000001);
  wire in_susp_rgn = susp_q && ((pbase & emask) == ebase_q);
  wire go_prog = cs_rise & is_qpp & len_q & qe & wel_q & idle
    & !in_susp_rgn & !sfpe_prot_hit(pbase, sfpe_pkg::LOG_PAGE, tb, bp, sec);
  wire go_erase = cs_rise & (is_se | is_b32 | is_b64) & len_addr & wel_q
    & idle & !susp_q & !sfpe_prot_hit(rbase, rlog, tb, bp, sec);
  wire go_chip = cs_rise & is_ce & len_op & wel_q & idle & !susp_q
    & bp == 3'h0;
  wire go_susp = cs_rise & op_q == sfpe_pkg::OP_SUSP & len_op
    & st_q == SFPE_ERASE;
  wire go_res = cs_rise & op_q == sfpe_pkg::OP_RES & len_op & idle
    & susp_q;
  wire go_wren = cs_rise & op_q == sfpe_pkg::OP_WREN & len_op & idle;
  wire go_wrdi = cs_rise & op_q == sfpe_pkg::OP_WRDI & len_op & idle;
  wire [31:0] ecyc = is_se ? SECT_CYC : is_b32 ? HALF_CYC : FULL_CYC;
  wire cnt_done = cnt_q == 32'h0;
  wire drain_done = drain_q[8];
  wire fin = (cnt_done && (st_q == SFPE_ERASE || st_q == SFPE_CHIP)) ||
             (cnt_done && drain_done && st_q == SFPE_PROG);

  // Self-timed engine
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= SFPE_IDLE;
      cnt_q <= '0;
      left_q <= '0;
      susp_q <= 1'b0;
      ebase_q <= '0;
      elog_q <= '0;
      pbase_q <= '0;
      drain_q <= '0;
    end else begin
      case (st_q)
        SFPE_IDLE: begin
          if (go_prog) begin
            st_q <= SFPE_PROG;
            cnt_q <= PROG_CYC;
            pbase_q <= pbase;
            drain_q <= '0;
          end else if (go_erase) begin
            st_q <= SFPE_ERASE;
            cnt_q <= ecyc;
            ebase_q <= rbase;
            elog_q <= rlog;
          end else if (go_chip) begin
            st_q <= SFPE_CHIP;
            cnt_q <= CHIP_CYC;
            ebase_q <= '0;
            elog_q <= 5'(ADDR_W);
          end else if (go_res) begin
            st_q <= SFPE_ERASE;
            cnt_q <= left_q;
            susp_q <= 1'b0;
          end
        end
        SFPE_PROG: begin
          if (!drain_done) begin
            drain_q <= drain_q + 9'h001;
          end
          if (!cnt_done) begin
            cnt_q <= cnt_q - 32'h1;
          end else if (drain_done) begin
            st_q <= SFPE_IDLE;
          end
        end
        SFPE_ERASE: begin
          if (go_susp) begin
            st_q <= SFPE_HALT;
            left_q <= cnt_q;
            cnt_q <= SUSP_CYC;
          end else if (!cnt_done) begin
            cnt_q <= cnt_q - 32'h1;
          end else begin
            st_q <= SFPE_IDLE;
          end
        end
        SFPE_CHIP: begin
          if (!cnt_done) begin
            cnt_q <= cnt_q - 32'h1;
          end else begin
            st_q <= SFPE_IDLE;
          end
        end
        SFPE_HALT: begin
          if (!cnt_done) begin
            cnt_q <= cnt_q - 32'h1;
          end else begin
            st_q <= SFPE_IDLE;
            susp_q <= 1'b1;
          end
        end
        default: begin
          st_q <= SFPE_IDLE;
        end
      endcase
    end
  end

  // Write latch: completion clears it; a same-edge enable cannot occur
  // because enables are only taken while idle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wel_q <= 1'b0;
    end else if (go_wren) begin
      wel_q <= 1'b1;
    end else if (fin || go_wrdi) begin
      wel_q <= 1'b0;
    end
  end

  // Array port: program writes stream out, erase lands at completion so
  // a suspended region keeps its old content until resumed
  wire [7:0] didx = drain_q[7:0];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      arr_wr_en <= 1'b0;
      arr_wr_addr <= '0;
      arr_wr_data <= '0;
      arr_erase_en <= 1'b0;
      arr_erase_base <= '0;
      arr_erase_log2 <= '0;
    end else begin
      arr_wr_en <= st_q == SFPE_PROG && !drain_done && bvld_q[didx];
      arr_wr_addr <= pbase_q | {16'h0000, didx};
      arr_wr_data <= pbuf[didx];
      arr_erase_en <= cnt_done &&
        (st_q == SFPE_ERASE || st_q == SFPE_CHIP) && !go_susp;
      arr_erase_base <= ebase_q;
      arr_erase_log2 <= elog_q;
    end
  end

  // APB slave, zero wait states
  wire acc = psel & penable;
  wire hit_ctrl = paddr == sfpe_pkg::ADDR_CTRL;
  wire hit_stat = paddr == sfpe_pkg::ADDR_STAT;
  wire [31:0] stat_word = {28'h0000000, susp_q, wel_q, busy, 1'b0};
  assign pready = 1'b1;
  assign pslverr = acc & !hit_ctrl & !hit_stat;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= sfpe_pkg::CTRL_RST;
    end else if (acc && pwrite && hit_ctrl && !susp_q) begin
      ctrl_q <= pwdata[5:0];
    end
  end
  assign prdata = !acc ? 32'h0 :
                  hit_ctrl ? {26'h0000000, ctrl_q} :
                  hit_stat ? stat_word : 32'h0;
endmodule // sfpe_ctrl

// ==== sfpe_pkg.sv ====
// Purpose: Shared constants for the flash program/erase sequencer.
// Assumes: System clock of 250 MHz; 24-bit flash addresses.
// Notes:   Register offsets are byte addresses on a 32-bit APB.
package sfpe_pkg;
  localparam int CLK_MHZ = 250;
  // Instruction codes
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hd8;
  localparam logic [7:0] OP_CE1 = 8'hc7;
  localparam logic [7:0] OP_CE2 = 8'h60;
  localparam logic [7:0] OP_SUSP = 8'h75;
  localparam logic [7:0] OP_RES = 8'h7a;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  // Frame lengths in serial clock rising edges
  localparam logic [11:0] RISE_OP = 12'h008;
  localparam logic [11:0] RISE_ADDR = 12'h020;
  localparam logic [11:0] RISE_QADDR_END = 12'h00e;
  localparam logic [11:0] RISE_QMIN = 12'h010;
  localparam logic [11:0] RISE_MAX = 12'hfff;
  // Region sizes as log2 of bytes
  localparam logic [4:0] LOG_PAGE = 5'h08;
  localparam logic [4:0] LOG_SECT = 5'h0c;
  localparam logic [4:0] LOG_BLK32 = 5'h0f;
  localparam logic [4:0] LOG_BLK64 = 5'h10;
  localparam logic [4:0] LOG_SEC_MAX = 5'h0f;
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam logic [2:0] BP_CAP = 3'h6;
  // APB map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  // Control register fields
  localparam int CTRL_QE = 0;
  localparam int CTRL_TB = 1;
  localparam int CTRL_BP_LO = 2;
  localparam int CTRL_SEC = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // Serial status byte fields
  localparam int SR_BUSY = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_TB = 5;
  localparam int SR_SEC = 6;
endpackage

// ==== sfpe_ctrl_checker.sv ====
// Purpose: Port-level checks for the program/erase sequencer.
// Assumes: Bound to sfpe_ctrl; single clock domain.
// Notes:   Watches array pulses, lane enables and bus answers.
`timescale 1ns/100ps
module sfpe_ctrl_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic spi_cs_n,
  input wire logic data_lane0_oe,
  input wire logic data_lane1_oe,
  input wire logic data_lane2_oe,
  input wire logic data_lane3_oe,
  input wire logic arr_wr_en,
  input wire logic arr_erase_en,
  input wire logic [23:0] arr_erase_base,
  input wire logic [4:0] arr_erase_log2
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire mapped = paddr == 8'h00 || paddr == 8'h04;
  wire [23:0] low_mask = (24'h1 << arr_erase_log2) - 24'h1;

  chk_erase_aligned: assert property (arr_erase_en |->
    (arr_erase_base & low_mask) == 24'h0) else $error("erase base off");
  chk_erase_size: assert property (arr_erase_en |->
    arr_erase_log2 inside {5'h0c, 5'h0f, 5'h10, 5'h15})
    else $error("erase size wrong");
  chk_erase_spaced: assert property (arr_erase_en |=>
    !arr_erase_en [*8]) else $error("erase pulses too close");
  chk_wr_erase_apart: assert property (arr_wr_en |->
    !arr_erase_en) else $error("write and erase together");
  chk_lane1_quiet: assert property (spi_cs_n [*8] |->
    !data_lane1_oe) else $error("lane1 driven while deselected");
  chk_spare_lanes: assert property (
    !(data_lane0_oe || data_lane2_oe || data_lane3_oe))
    else $error("input lane driven");
  chk_unmapped_err: assert property (acc && !mapped |->
    pslverr && prdata == 32'h0) else $error("unmapped not refused");
  chk_mapped_ok: assert property (acc && mapped |->
    pready && !pslverr) else $error("mapped access refused");
  chk_idle_quiet: assert property (!acc |->
    prdata == 32'h0 && !pslverr) else $error("bus answer outside access");

  cover property (arr_erase_en && arr_erase_log2 == 5'h0c);
  cover property (arr_wr_en);
  cover property (acc && pslverr);
  cover property ($rose(data_lane1_oe));
endmodule // sfpe_ctrl_checker

// ==== sfpe_spi_host.sv ====
// Purpose: Serial host model driving select, clock and four lanes.
// Assumes: Mode 0; each clock phase lasts 6 system clocks.
// Notes:   Released lanes show the inverse of the last value.
`timescale 1ns/100ps
module sfpe_spi_host (
  input wire logic clk_sys,
  output logic cs_n,
  output logic sclk,
  output logic [3:0] lanes,
  input wire logic lane1_in
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    lanes = 4'h0;
  end

  // Mode m: 0 opcode, 1 serial address, 2 quad address and nd nibbles,
  // 3 status byte read. Cut drops beats to break framing on purpose.
  task automatic send(input logic [7:0] op, input logic [23:0] a,
      input int m, input int nd, input int cut, output logic [7:0] rd);
    int nb;
    logic [3:0] b;
    rd = 8'h00;
    b = 4'h0;
    nb = 8 + (m == 1 ? 24 : m == 2 ? 6 + nd : m == 3 ? 8 : 0) - cut;
    cs_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      if (i < 8) b = {3'h0, op[7 - i]};
      else if (m == 1) b = {3'h0, a[31 - i]};
      else if (m == 2 && i < 14) b = a[4 * (13 - i) +: 4];
      else b = 4'(i - 14);
      sclk <= 1'b0;
      lanes <= b;
      repeat (6) @(posedge clk_sys);
      rd = {rd[6:0], lane1_in};
      sclk <= 1'b1;
      repeat (6) @(posedge clk_sys);
    end
    sclk <= 1'b0;
    repeat (6) @(posedge clk_sys);
    cs_n <= 1'b1;
    lanes <= ~b;
    repeat (12) @(posedge clk_sys);
  endtask
endmodule // sfpe_spi_host

// ==== serial_flash_program_erase_control_tb.sv ====
// Purpose: Self-checking bench for the program/erase sequencer.
// Assumes: Timed cycles shortened to 1 us, sector erase to 2 us;
//          suspend keeps its default time, so polling allows for it.
// Notes:   Sector granularity stays 0, so edge blocks are never at risk.
`timescale 1ns/100ps
module serial_flash_program_erase_control_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, wq[$], eq[$];
  logic pready, pslverr, spi_cs_n, spi_clk, e;
  logic [3:0] lanes;
  wire [3:0] lo, oe;
  wire lane1_w = oe[1] ? lo[1] : lanes[1];
  logic arr_wr_en, arr_erase_en;
  logic [23:0] arr_wr_addr, arr_erase_base;
  logic [7:0] arr_wr_data, sr;
  logic [4:0] arr_erase_log2;
  logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
  logic [4:0] lg [5] = '{5'h0c, 5'h0f, 5'h10, 5'h15, 5'h15};
  int failures = 0, check_count = 0;

  always #2 clk_sys = ~clk_sys;

  sfpe_ctrl #(.PROG_TIME_US(1), .SECT_TIME_US(2),
    .HALF_BLOCK_ERASE_TIME_US(1), .FULL_BLOCK_ERASE_TIME_US(1),
    .WHOLE_ARRAY_ERASE_TIME_US(1)) dut_u (
    .clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .spi_cs_n, .spi_clk, .data_lane0_i(lanes[0]),
    .data_lane0_o(lo[0]), .data_lane0_oe(oe[0]), .data_lane1_i(lane1_w),
    .data_lane1_o(lo[1]), .data_lane1_oe(oe[1]), .data_lane2_i(lanes[2]),
    .data_lane2_o(lo[2]), .data_lane2_oe(oe[2]), .data_lane3_i(lanes[3]),
    .data_lane3_o(lo[3]), .data_lane3_oe(oe[3]), .arr_wr_en, .arr_wr_addr,
    .arr_wr_data, .arr_erase_en, .arr_erase_base, .arr_erase_log2);

  sfpe_spi_host host_u (.clk_sys, .cs_n(spi_cs_n), .sclk(spi_clk),
    .lanes, .lane1_in(lane1_w));

  always @(posedge clk_sys) begin
    if (arr_wr_en) wq.push_back({arr_wr_addr, arr_wr_data});
    if (arr_erase_en) eq.push_back({3'h0, arr_erase_log2, arr_erase_base});
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic stat(input logic [31:0] x);
    apb(1'b0, 8'h04, 32'h0);
    cmp(r, x);
  endtask

  // Poll rather than wait fixed time: cycle lengths are design choices
  task automatic idle();
    for (int i = 0; i < 2000; i++) begin
      apb(1'b0, 8'h04, 32'h0);
      if (r[1] === 1'b0) break;
    end
  endtask

  task automatic wren();
    host_u.send(8'h06, 24'h0, 0, 0, 0, sr);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk_sys);
    failures++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, 8'h00, 32'h0);
    cmp(r, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    cmp({31'h0, e}, 32'h1);
    stat(32'h0);
    $display("test reset done");
    wren();
    host_u.send(8'h32, 24'h0001fe, 2, 6, 0, sr);
    stat(32'h4);
    apb(1'b1, 8'h00, 32'h1);
    host_u.send(8'h32, 24'h0001fe, 2, 6, 0, sr);
    stat(32'h6);
    idle();
    stat(32'h0);
    cmp(wq.size(), 3);
    // Buffer drains in page order, so the wrapped byte comes out first
    cmp(wq.pop_front(), {24'h000100, 8'h45});
    cmp(wq.pop_front(), {24'h0001fe, 8'h01});
    cmp(wq.pop_front(), {24'h0001ff, 8'h23});
    $display("test program done");
    for (int k = 0; k < 5; k++) begin
      wren();
      host_u.send(ops[k], 24'h012345, k < 3 ? 1 : 0, 0, 0, sr);
      host_u.send(8'h05, 24'h0, 3, 0, 0, sr);
      cmp(sr[1:0], 2'b11);
      idle();
      stat(32'h0);
      cmp(eq.size(), 1);
      cmp(eq.pop_front(), {3'h0, lg[k], 24'h012345 & ~((24'h1 << lg[k]) - 24'h1)});
    end
    $display("test erase done");
    host_u.send(8'h20, 24'h0, 1, 0, 0, sr);
    stat(32'h0);
    wren();
    host_u.send(8'h20, 24'h0, 1, 0, 1, sr);
    stat(32'h4);
    apb(1'b1, 8'h00, 32'h5);
    host_u.send(8'h20, 24'h1f0000, 1, 0, 0, sr);
    stat(32'h4);
    host_u.send(8'hc7, 24'h0, 0, 0, 0, sr);
    stat(32'h4);
    host_u.send(8'h7a, 24'h0, 0, 0, 0, sr);
    stat(32'h4);
    apb(1'b1, 8'h00, 32'h1);
    cmp(eq.size(), 0);
    $display("test refuse done");
    host_u.send(8'h20, 24'h003000, 1, 0, 0, sr);
    host_u.send(8'h75, 24'h0, 0, 0, 0, sr);
    idle();
    stat(32'hc);
    host_u.send(8'h20, 24'h005000, 1, 0, 0, sr);
    stat(32'hc);
    host_u.send(8'h7a, 24'h0, 0, 0, 0, sr);
    apb(1'b0, 8'h04, 32'h0);
    cmp({31'h0, r[1]}, 32'h1);
    idle();
    stat(32'h0);
    cmp(eq.pop_front(), {3'h0, 5'h0c, 24'h003000});
    wren();
    host_u.send(8'h32, 24'h000400, 2, 2, 0, sr);
    host_u.send(8'h75, 24'h0, 0, 0, 0, sr);
    idle();
    stat(32'h0);
    cmp(wq.pop_front(), {24'h000400, 8'h01});
    cmp(eq.size() + wq.size(), 0);
    $display("test suspend done");
    finish_test();
  end
endmodule // serial_flash_program_erase_control_tb

bind sfpe_ctrl sfpe_ctrl_checker chk_u (.clk_sys, .rst, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .spi_cs_n, .data_lane0_oe,
  .data_lane1_oe, .data_lane2_oe, .data_lane3_oe, .arr_wr_en,
  .arr_erase_en, .arr_erase_base, .arr_erase_log2);
